// file: rtl/aos_consts.svh
// Constants of the add-only EPROM memory-function logic.
// Assumes one clock domain; included by every design file that needs a figure.
// Notes on behaviour
// - A 704-bit status memory exists, reached only by its own commands.
// - Status bytes 000-007H protect main pages; protected pages refuse programming, still read.
// - Status bytes 020-027H protect each page's redirection byte from alteration.
// - Status bytes 040-047H are plain application flags with no internal effect.
// - Status bytes 100H-13FH are redirection bytes, stored but never acted upon.
// - Programming only clears bits; nothing ever sets a zero bit back to one.
// - Unimplemented status addresses read FFH and ignore writes.
// - Start addresses above 7FFH lose their five upper bits.
// - Writes go byte-wise through an 8-bit buffer, committed on programming pulse.
// - All bits travel least significant bit first.
// - First address byte is bits 7-0, second is bits 15-8.
// - Command F0H streams main-memory bytes from the address to the end.
// - After the last main byte, sixteen slots return CRC-16 over command, address, data.
// - After the main CRC, slots return ones; a read cut short gets no CRC.
// - Command AAH streams status bytes to page end, then CRC-16 including header.
// - Each later status page gets a fresh CRC over its data bytes only.
// - After the final status page CRC, slots return ones until reset.
// - Memory commands are ignored until ROM-level selection completes after reset.
`ifndef AOS_CONSTS_SVH
`define AOS_CONSTS_SVH
`define AOS_CMD_READ_MEM 8'hf0
`define AOS_CMD_READ_STAT 8'haa
`define AOS_CMD_WRITE_MEM 8'h0f
`define AOS_CMD_WRITE_STAT 8'h55
`define AOS_DATA_BYTES 2048
`define AOS_LAST_ADDR 11'h7ff
`define AOS_PAGE_END 3'h7
`define AOS_BYTE_END 4'h7
`define AOS_CRC_END 4'hf
`define AOS_ADDR_HI_BITS 4'h3
`define AOS_ERASED 8'hff
`define AOS_CRC_POLY 16'ha001
`define AOS_CRC_INIT 16'h0000
`define AOS_STAT_BYTES 88
`define AOS_GRP_WP 8'h00
`define AOS_GRP_RWP 8'h04
`define AOS_GRP_USED 8'h08
`define AOS_GRP_REDIR 5'h04
`define AOS_IDX_WP 7'h00
`define AOS_IDX_RWP 7'h08
`define AOS_IDX_USED 7'h10
`define AOS_IDX_REDIR 7'h18
`endif

// file: rtl/aos_pkg.sv
// Types shared by the add-only EPROM memory-function logic.
// Assumes the constants header is included by the modules themselves.
package aos_pkg;
  typedef enum logic [3:0] {
    AOS_IDLE = 4'h0,
    AOS_CMD = 4'h1,
    AOS_ADRL = 4'h3,
    AOS_ADRH = 4'h2,
    AOS_RDATA = 4'h6,
    AOS_RCRC = 4'h7,
    AOS_ONES = 4'h5,
    AOS_WDATA = 4'h4,
    AOS_WPROG = 4'hc
  } aos_state_type;
  typedef enum logic {AOS_MAIN = 1'b0, AOS_STATUS = 1'b1} aos_field_type;
  typedef struct packed {
    logic en;
    aos_field_type field;
    logic [10:0] addr;
    logic [7:0] data;
  } aos_prog_type;
  typedef struct packed {
    logic hit;
    logic [6:0] idx;
  } aos_loc_type;
endpackage : aos_pkg

// file: rtl/aos_crc16.sv
// Bit-serial CRC-16 generator, reflected form, fed least significant bit first.
// Assumes clear and shift are never asked for in the same cycle.
`include "aos_consts.svh"
module aos_crc16 import aos_pkg::*; (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic clear_in,
  input wire logic shift_in,
  input wire logic bit_in,
  output logic [15:0] crc_out
);
  logic [15:0] next_crc;

  always_comb begin
    next_crc = crc_out;
    if (clear_in) begin
      next_crc = `AOS_CRC_INIT;
    end else if (shift_in) begin
      next_crc = {1'b0, crc_out[15:1]} ^ ((crc_out[0] ^ bit_in) ? `AOS_CRC_POLY : 16'h0000);
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      crc_out <= `AOS_CRC_INIT;
    end else begin
      crc_out <= next_crc;
    end
  end
endmodule // aos_crc16

// file: rtl/aos_mem.sv
// Main EPROM data array and the status bytes, with their protection checks.
// Assumes a programming request is a single-cycle strobe from the command logic.
`include "aos_consts.svh"
module aos_mem import aos_pkg::*; #(
  parameter int DATA_BYTES = `AOS_DATA_BYTES
) (
  input wire logic clk_in,
  input wire aos_prog_type prog_in,
  input wire aos_field_type rd_field_in,
  input wire logic [10:0] rd_addr_in,
  output logic [7:0] rd_data_out,
  output logic wr_ok_out
);
  // EPROM cells hold no reset; the erased state is all ones.
  logic [7:0] main_mem [DATA_BYTES] = '{default: `AOS_ERASED};
  logic [7:0] stat_mem [`AOS_STAT_BYTES] = '{default: `AOS_ERASED};
  aos_loc_type rd_loc;
  aos_loc_type wr_loc;
  logic [5:0] wr_page;

  if (DATA_BYTES != `AOS_DATA_BYTES) begin : g_size_check
    $error("aos_mem serves an 11-bit address space only");
  end

  // Folds the sparse status address space onto the implemented bytes.
  function automatic aos_loc_type stat_loc(input logic [10:0] a);
    aos_loc_type l;
    l = '0;
    if (a[10:3] == `AOS_GRP_WP) l = '{1'b1, `AOS_IDX_WP + {4'h0, a[2:0]}};
    else if (a[10:3] == `AOS_GRP_RWP) l = '{1'b1, `AOS_IDX_RWP + {4'h0, a[2:0]}};
    else if (a[10:3] == `AOS_GRP_USED) l = '{1'b1, `AOS_IDX_USED + {4'h0, a[2:0]}};
    else if (a[10:6] == `AOS_GRP_REDIR) l = '{1'b1, `AOS_IDX_REDIR + {1'b0, a[5:0]}};
    return l;
  endfunction

  always_comb begin
    rd_loc = stat_loc(rd_addr_in);
    wr_loc = stat_loc(prog_in.addr);
    wr_page = (prog_in.field == AOS_MAIN) ? prog_in.addr[10:5] : prog_in.addr[5:0];
    if (rd_field_in == AOS_MAIN) begin
      rd_data_out = main_mem[rd_addr_in];
    end else begin
      rd_data_out = rd_loc.hit ? stat_mem[rd_loc.idx] : `AOS_ERASED;
    end
    if (prog_in.field == AOS_MAIN) begin
      wr_ok_out = stat_mem[`AOS_IDX_WP + {4'h0, wr_page[5:3]}][wr_page[2:0]];
    end else if (!wr_loc.hit) begin
      wr_ok_out = 1'b0;
    end else if (wr_loc.idx >= `AOS_IDX_REDIR) begin
      wr_ok_out = stat_mem[`AOS_IDX_RWP + {4'h0, wr_page[5:3]}][wr_page[2:0]];
    end else begin
      wr_ok_out = 1'b1;
    end
  end

  // Only an AND with the old byte is possible, so a zero never returns to one.
  always_ff @(posedge clk_in) begin
    if (prog_in.en && wr_ok_out) begin
      if (prog_in.field == AOS_MAIN) begin
        main_mem[prog_in.addr] <= main_mem[prog_in.addr] & prog_in.data;
      end else begin
        stat_mem[wr_loc.idx] <= stat_mem[wr_loc.idx] & prog_in.data;
      end
    end
  end
endmodule // aos_mem

// file: rtl/aos_top.sv
// Memory-function command interpreter of the add-only EPROM.
// Assumes a same-clock link layer that turns line time slots into strobes,
// and a detector that reports the programming pulse as a one-cycle strobe.
`include "aos_consts.svh"
module aos_top import aos_pkg::*; (
  input wire logic REF_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic RESET_PULSE_IN,
  input wire logic ROM_SELECTED_IN,
  input wire logic WRITE_SLOT_IN,
  input wire logic WRITE_BIT_IN,
  input wire logic READ_SLOT_IN,
  input wire logic PROG_PULSE_IN,
  output logic READ_BIT_OUT,
  output logic READ_VALID_OUT,
  output logic PROG_DONE_OUT,
  output logic PROG_REFUSED_OUT,
  output logic BUSY_OUT
);
  // ==========================================================
  // Declarations
  aos_state_type state;
  aos_state_type next_state;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [10:0] cur_addr;
  logic [10:0] next_cur_addr;
  aos_field_type field;
  aos_field_type next_field;
  logic is_write;
  logic next_is_write;
  logic [7:0] wbuf;
  logic [7:0] next_wbuf;
  logic next_read_bit;
  logic next_read_valid;
  logic next_prog_done;
  logic next_prog_refused;
  logic next_busy;
  logic [7:0] rx_byte;
  logic crc_clear;
  logic crc_shift;
  logic crc_bit;
  logic [15:0] crc;
  logic [7:0] rd_data;
  logic wr_ok;
  aos_prog_type prog;

  // ==========================================================
  // Submodules
  aos_crc16 u_crc (
    .clk_in(REF_CLK_IN),
    .resetn_in(RESETN_IN),
    .clear_in(crc_clear),
    .shift_in(crc_shift),
    .bit_in(crc_bit),
    .crc_out(crc)
  );

  aos_mem u_mem (
    .clk_in(REF_CLK_IN),
    .prog_in(prog),
    .rd_field_in(field),
    .rd_addr_in(cur_addr),
    .rd_data_out(rd_data),
    .wr_ok_out(wr_ok)
  );

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_cur_addr = cur_addr;
    next_field = field;
    next_is_write = is_write;
    next_wbuf = wbuf;
    next_read_bit = READ_BIT_OUT;
    next_read_valid = 1'b0;
    next_prog_done = 1'b0;
    next_prog_refused = 1'b0;
    crc_clear = 1'b0;
    crc_shift = 1'b0;
    crc_bit = WRITE_BIT_IN;
    prog = '{1'b0, field, cur_addr, wbuf};
    rx_byte = {WRITE_BIT_IN, shreg[7:1]};
    // Slots outside idle and the data and CRC phases answer with ones.
    if (READ_SLOT_IN && state != AOS_IDLE) begin
      next_read_valid = 1'b1;
      next_read_bit = 1'b1;
    end
    if (RESET_PULSE_IN) begin
      next_state = AOS_IDLE;
      next_bitcnt = 4'h0;
    end else begin
      unique case (state)
        AOS_IDLE: begin
          if (ROM_SELECTED_IN) begin
            next_state = AOS_CMD;
            next_bitcnt = 4'h0;
            crc_clear = 1'b1;
          end
        end
        AOS_CMD, AOS_ADRL, AOS_ADRH, AOS_WDATA: begin
          if (WRITE_SLOT_IN) begin
            next_shreg = rx_byte;
            crc_shift = (state != AOS_WDATA);
            // The trailer must see the address as truncated, so that a master that
            // sent upper bits finds its own CRC disagreeing.
            if (state == AOS_ADRH && bitcnt >= `AOS_ADDR_HI_BITS) begin
              crc_bit = 1'b0;
            end
            next_bitcnt = bitcnt + 4'h1;
            if (bitcnt == `AOS_BYTE_END) begin
              next_bitcnt = 4'h0;
              if (state == AOS_CMD) begin
                next_state = AOS_ADRL;
                next_field = AOS_MAIN;
                next_is_write = 1'b0;
                if (rx_byte == `AOS_CMD_READ_STAT) begin
                  next_field = AOS_STATUS;
                end else if (rx_byte == `AOS_CMD_WRITE_MEM) begin
                  next_is_write = 1'b1;
                end else if (rx_byte == `AOS_CMD_WRITE_STAT) begin
                  next_field = AOS_STATUS;
                  next_is_write = 1'b1;
                end else if (rx_byte != `AOS_CMD_READ_MEM) begin
                  next_state = AOS_ONES;
                end
              end else if (state == AOS_ADRL) begin
                next_cur_addr[7:0] = rx_byte;
                next_state = AOS_ADRH;
              end else if (state == AOS_ADRH) begin
                // Upper five address bits are dropped, in the address and in the CRC alike.
                next_cur_addr[10:8] = rx_byte[2:0];
                next_state = is_write ? AOS_WDATA : AOS_RDATA;
              end else begin
                next_wbuf = rx_byte;
                next_state = AOS_WPROG;
              end
            end
          end
        end
        AOS_RDATA: begin
          if (READ_SLOT_IN) begin
            next_read_bit = rd_data[bitcnt[2:0]];
            crc_bit = rd_data[bitcnt[2:0]];
            crc_shift = 1'b1;
            next_bitcnt = bitcnt + 4'h1;
            if (bitcnt == `AOS_BYTE_END) begin
              next_bitcnt = 4'h0;
              if (field == AOS_STATUS ? cur_addr[2:0] == `AOS_PAGE_END
                                      : cur_addr == `AOS_LAST_ADDR) begin
                next_state = AOS_RCRC;
              end else begin
                next_cur_addr = cur_addr + 11'h001;
              end
            end
          end
        end
        AOS_RCRC: begin
          if (READ_SLOT_IN) begin
            next_read_bit = ~crc[bitcnt];
            next_bitcnt = bitcnt + 4'h1;
            if (bitcnt == `AOS_CRC_END) begin
              next_bitcnt = 4'h0;
              if (field == AOS_STATUS && cur_addr != `AOS_LAST_ADDR) begin
                next_cur_addr = cur_addr + 11'h001;
                crc_clear = 1'b1;
                next_state = AOS_RDATA;
              end else begin
                next_state = AOS_ONES;
              end
            end
          end
        end
        AOS_ONES: begin
          next_state = AOS_ONES;
        end
        AOS_WPROG: begin
          if (PROG_PULSE_IN) begin
            prog.en = 1'b1;
            next_prog_done = wr_ok;
            next_prog_refused = !wr_ok;
            next_state = AOS_ONES;
          end
        end
        default: begin
          next_state = AOS_IDLE;
        end
      endcase
    end
    next_busy = (next_state != AOS_IDLE);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state <= AOS_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      cur_addr <= 11'h000;
      field <= AOS_MAIN;
      is_write <= 1'b0;
      wbuf <= `AOS_ERASED;
      READ_BIT_OUT <= 1'b1;
      READ_VALID_OUT <= 1'b0;
      PROG_DONE_OUT <= 1'b0;
      PROG_REFUSED_OUT <= 1'b0;
      BUSY_OUT <= 1'b0;
    end else begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      cur_addr <= next_cur_addr;
      field <= next_field;
      is_write <= next_is_write;
      wbuf <= next_wbuf;
      READ_BIT_OUT <= next_read_bit;
      READ_VALID_OUT <= next_read_valid;
      PROG_DONE_OUT <= next_prog_done;
      PROG_REFUSED_OUT <= next_prog_refused;
      BUSY_OUT <= next_busy;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  sequence last_data_slot;
    state == AOS_RDATA && READ_SLOT_IN && !RESET_PULSE_IN && bitcnt == `AOS_BYTE_END;
  endsequence

  sequence last_crc_slot;
    state == AOS_RCRC && READ_SLOT_IN && !RESET_PULSE_IN && bitcnt == `AOS_CRC_END;
  endsequence

  cmd_gate_a: assert property (state == AOS_IDLE && !ROM_SELECTED_IN |=>
    state == AOS_IDLE && !BUSY_OUT) else $error("command logic left idle unselected");

  reset_abort_a: assert property (RESET_PULSE_IN |=> state == AOS_IDLE && bitcnt == 4'h0)
    else $error("reset pulse did not abort");

  main_crc_a: assert property (last_data_slot and (field == AOS_MAIN &&
    cur_addr == `AOS_LAST_ADDR) |=> state == AOS_RCRC) else $error("no CRC after memory end");

  stat_page_a: assert property (last_data_slot and (field == AOS_STATUS &&
    cur_addr[2:0] == `AOS_PAGE_END) |=> state == AOS_RCRC) else $error("no CRC at page end");

  stat_next_a: assert property (last_crc_slot and (field == AOS_STATUS &&
    cur_addr != `AOS_LAST_ADDR) |=> state == AOS_RDATA && crc == `AOS_CRC_INIT &&
    cur_addr[2:0] == 3'h0) else $error("next status page not restarted");

  ones_tail_a: assert property (state == AOS_ONES && READ_SLOT_IN |=>
    READ_BIT_OUT && READ_VALID_OUT) else $error("tail slot did not read one");

  lsb_first_a: assert property (state == AOS_RDATA && READ_SLOT_IN && !RESET_PULSE_IN &&
    bitcnt == 4'h0 |=> READ_BIT_OUT == $past(rd_data[0])) else $error("data not LSB first");

  crc_hold_a: assert property (state == AOS_RCRC && !RESET_PULSE_IN && !crc_clear |=>
    $stable(crc)) else $error("CRC changed while being sent");

  prot_refuse_a: assert property (state == AOS_WPROG && PROG_PULSE_IN && !RESET_PULSE_IN &&
    !wr_ok |=> PROG_REFUSED_OUT && !PROG_DONE_OUT ##1 !PROG_REFUSED_OUT)
    else $error("protected byte not refused");

  // Programming takes one byte per command; afterwards only ones are answered.
  sequence prog_strobe;
    state == AOS_WPROG && PROG_PULSE_IN && !RESET_PULSE_IN;
  endsequence

  prog_done_a: assert property (prog_strobe and wr_ok |=>
    PROG_DONE_OUT && !PROG_REFUSED_OUT ##1 !PROG_DONE_OUT)
    else $error("accepted byte not reported");

  prog_end_a: assert property (prog_strobe |=> state == AOS_ONES)
    else $error("write did not end after one byte");

  prog_wait_a: assert property (state == AOS_WPROG && !PROG_PULSE_IN &&
    !RESET_PULSE_IN |=> state == AOS_WPROG) else $error("write left without a pulse");

  ones_stay_a: assert property (state == AOS_ONES && !RESET_PULSE_IN |=>
    state == AOS_ONES) else $error("ones tail left without reset");

  idle_silent_a: assert property (state == AOS_IDLE |=> !READ_VALID_OUT)
    else $error("read slot answered before selection");

  read_answer_a: assert property (READ_SLOT_IN && state != AOS_IDLE |=>
    READ_VALID_OUT) else $error("read slot not answered");

  sel_start_a: assert property (state == AOS_IDLE && ROM_SELECTED_IN &&
    !RESET_PULSE_IN |=> state == AOS_CMD && crc == `AOS_CRC_INIT)
    else $error("CRC not cleared at selection");

  main_step_a: assert property (last_data_slot and (field == AOS_MAIN &&
    cur_addr != `AOS_LAST_ADDR) |=> state == AOS_RDATA && cur_addr == $past(cur_addr) + 11'h001)
    else $error("main read did not advance");

  data_hold_a: assert property (state == AOS_RDATA && !READ_SLOT_IN &&
    !RESET_PULSE_IN |=> $stable(cur_addr) && $stable(bitcnt))
    else $error("read position moved without a slot");
endmodule // aos_top

// file: test/aos_master_model.sv
// Behavioural model of the line master that drives the memory-function logic.
// Assumes a same-clock link layer: every slot, selection and pulse is a one-cycle strobe.
module aos_master_model (
  input wire logic clk_in,
  input wire logic read_bit_in,
  input wire logic read_valid_in,
  input wire logic prog_done_in,
  input wire logic prog_refused_in,
  input wire logic busy_in,
  output logic reset_pulse_out,
  output logic rom_selected_out,
  output logic write_slot_out,
  output logic write_bit_out,
  output logic read_slot_out,
  output logic prog_pulse_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reset_pulse_out = 1'b0;
    rom_selected_out = 1'b0;
    write_slot_out = 1'b0;
    write_bit_out = 1'b0;
    read_slot_out = 1'b0;
    prog_pulse_out = 1'b0;
  end

  // ==========================================================================
  // Sequence control
  // A fresh reset pulse opens every sequence, so a bad trailer is never acted on.
  task automatic line_reset();
    int n;
    @(posedge clk_in);
    reset_pulse_out <= 1'b1;
    @(posedge clk_in);
    reset_pulse_out <= 1'b0;
    n = 0;
    while (busy_in !== 1'b0 && n < 16) begin
      @(posedge clk_in);
      n++;
    end
    @(posedge clk_in);
    rom_selected_out <= 1'b1;
    @(posedge clk_in);
    rom_selected_out <= 1'b0;
  endtask

  // ==========================================================================
  // Bit slots
  // The data line shows the inverse between slots so a stale bit is never reused.
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_in);
      write_slot_out <= 1'b1;
      write_bit_out <= b[i];
      @(posedge clk_in);
      write_slot_out <= 1'b0;
      write_bit_out <= ~b[i];
    end
  endtask

  task automatic read_bit(output logic v, output logic b);
    @(posedge clk_in);
    read_slot_out <= 1'b1;
    @(posedge clk_in);
    read_slot_out <= 1'b0;
    @(posedge clk_in);
    v = read_valid_in;
    b = read_bit_in;
  endtask

  task automatic read_byte(output logic [7:0] d, output logic ok);
    logic v;
    logic b;
    ok = 1'b1;
    for (int i = 0; i < 8; i++) begin
      read_bit(v, b);
      d[i] = b;
      ok = ok & v;
    end
  endtask

  task automatic prog(output logic done, output logic refused);
    @(posedge clk_in);
    prog_pulse_out <= 1'b1;
    @(posedge clk_in);
    prog_pulse_out <= 1'b0;
    @(posedge clk_in);
    done = prog_done_in;
    refused = prog_refused_in;
  endtask
endmodule // aos_master_model

// file: test/aos_top_tb.sv
// Self-checking bench of the memory-function interpreter against an integer model.
// Assumes the arrays start erased and keep their contents; one 125 MHz clock.
module aos_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fail_count++; $display("FAIL t=%0t got %h exp %h", $time, (got), (exp)); end end

  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic rst_pulse, rom_sel, wr_slot, wr_bit, rd_slot, prog_pulse;
  logic rd_bit, rd_valid, prog_done, prog_refused, busy;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int main_m[2048];
  int stat_m[2048];
  logic v, b;
  logic [7:0] dv;
  int r;

  always #4 ref_clk = ~ref_clk;

  aos_top DUT (.REF_CLK_IN(ref_clk), .RESETN_IN(resetn), .RESET_PULSE_IN(rst_pulse),
    .ROM_SELECTED_IN(rom_sel), .WRITE_SLOT_IN(wr_slot), .WRITE_BIT_IN(wr_bit),
    .READ_SLOT_IN(rd_slot), .PROG_PULSE_IN(prog_pulse), .READ_BIT_OUT(rd_bit),
    .READ_VALID_OUT(rd_valid), .PROG_DONE_OUT(prog_done), .PROG_REFUSED_OUT(prog_refused),
    .BUSY_OUT(busy));

  aos_master_model master (.clk_in(ref_clk), .read_bit_in(rd_bit), .read_valid_in(rd_valid),
    .prog_done_in(prog_done), .prog_refused_in(prog_refused), .busy_in(busy),
    .reset_pulse_out(rst_pulse), .rom_selected_out(rom_sel), .write_slot_out(wr_slot),
    .write_bit_out(wr_bit), .read_slot_out(rd_slot), .prog_pulse_out(prog_pulse));

  // ==========================================================================
  // Reference model
  function automatic int crc_upd(int crc, int d);
    for (int i = 0; i < 8; i++) begin
      if (((crc ^ (d >> i)) & 1) != 0) crc = (crc >> 1) ^ 'ha001;
      else crc = crc >> 1;
    end
    return crc;
  endfunction

  function automatic bit impl(int a);
    return a < 8 || (a >= 32 && a < 40) || (a >= 64 && a < 72) || (a >= 256 && a < 320);
  endfunction

  function automatic bit may_prog(bit st, int a);
    if (!st) return ((stat_m[a / 256] >> ((a / 32) % 8)) & 1) == 1;
    if (!impl(a)) return 1'b0;
    if (a >= 256) return ((stat_m[32 + (a - 256) / 8] >> ((a - 256) % 8)) & 1) == 1;
    return 1'b1;
  endfunction

  // ==========================================================================
  // Transactions
  task automatic start(logic [7:0] cmd, int a16);
    master.line_reset();
    master.send_byte(cmd);
    master.send_byte(a16[7:0]);
    master.send_byte(a16[15:8]);
  endtask

  task automatic do_write(bit st, int a, int d);
    logic done, refused;
    bit ok;
    ok = may_prog(st, a);
    start(st ? 8'h55 : 8'h0f, a);
    master.send_byte(d[7:0]);
    master.prog(done, refused);
    `CHK({done, refused}, ok ? 2'b10 : 2'b01)
    `CHK(busy, 1'b1)
    if (ok && st) stat_m[a] &= d;
    if (ok && !st) main_m[a] &= d;
  endtask

  // A redirection byte of FFH keeps the page; any other value names its replacement by complement.
  task automatic follow_redir(int p, int exp_page);
    logic [7:0] d;
    logic ok;
    start(8'haa, 'h100 + p);
    master.read_byte(d, ok);
    `CHK({ok, (d == 8'hff) ? 8'(p) : ~d}, {1'b1, 8'(exp_page)})
  endtask

  // Reads n data bytes, checking each trailer on the way; the sequence is cut by the next reset.
  task automatic rd(bit st, int a16, int n);
    logic [7:0] d;
    logic ok;
    logic [15:0] c;
    int a, crc;
    a = a16 & 'h7ff;
    crc = crc_upd(crc_upd(crc_upd(0, st ? 'haa : 'hf0), a & 'hff), a >> 8);
    start(st ? 8'haa : 8'hf0, a16);
    repeat (n) begin
      master.read_byte(d, ok);
      `CHK({ok, d}, {1'b1, 8'(st ? stat_m[a] : main_m[a])})
      crc = crc_upd(crc, st ? stat_m[a] : main_m[a]);
      a++;
      if (a == 2048 || (st && a % 8 == 0)) begin
        master.read_byte(d, ok);
        c[7:0] = d;
        master.read_byte(d, ok);
        c[15:8] = d;
        `CHK(c, 16'(~crc))
        crc = 0;
      end
    end
    if (a == 2048) begin
      master.read_byte(d, ok);
      `CHK({ok, d}, 9'h1ff)
    end
  endtask

  task automatic conclude();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Generous ceiling: the whole sequence needs well under ten thousand cycles.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      conclude();
    end
  end

  // ==========================================================================
  // Scenarios
  initial begin
    for (int i = 0; i < 2048; i++) begin
      main_m[i] = 'hff;
      stat_m[i] = 'hff;
    end
    r = $urandom(21);
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    master.read_bit(v, b);
    `CHK(v, 1'b0)
    `CHK(busy, 1'b0)
    do_write(0, 'h0a3, $urandom & 'hff);
    do_write(0, 'h0a3, 'hff);
    rd(0, 'h0a3, 1);
    do_write(1, 'h000, 'hdf);
    do_write(0, 'h0a5, 'h00);
    rd(0, 'h0a3, 1);
    do_write(1, 'h100, 'hfd);
    do_write(1, 'h020, 'hfe);
    do_write(1, 'h100, 'h00);
    follow_redir(0, 2);
    follow_redir(1, 1);
    do_write(0, 'h010, 'h3c);
    do_write(1, 'h040, 'h7f);
    do_write(1, 'h008, 'h00);
    do_write(1, 'h140, 'h00);
    rd(1, 'h000, 8);
    rd(1, 'h13f, 9);
    rd(1, 'h7f8, 8);
    rd(0, 'h07fe, 2);
    rd(0, 'hfffe, 2);
    start(8'h3c, 'h000);
    master.read_byte(dv, v);
    `CHK({v, dv}, 9'h1ff)
    conclude();
  end
endmodule // aos_top_tb
